// file: fcg_gain_channel.sv
// One channel: holds pending gain, applies on zero crossing or timeout
`timescale 1ns/1ps
module fcg_gain_channel #(
  parameter int TIMEOUT_CYCLES = fcg_pkg::ZC_TIMEOUT_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] target_in,
  input wire logic gate_in,
  input wire logic mute_req_in,
  input wire logic zero_cross_in,
  output logic [7:0] gain_out,
  output logic muted_out
);
  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  logic [2:0] zc_meta_q;
  logic [CW-1:0] wait_q;
  logic zc_rise;
  logic gain_pend;
  logic mute_pend;

  if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("Timeout must be at least one cycle");
  end

  assign zc_rise = zc_meta_q[1] & ~zc_meta_q[2];
  assign gain_pend = target_in != gain_out;
  assign mute_pend = mute_req_in != muted_out;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      zc_meta_q <= 3'h0;
    end else begin
      zc_meta_q <= {zc_meta_q[1:0], zero_cross_in};
    end
  end

  // Timeout counter runs while anything is pending
  always_ff @(posedge clk_in) begin
    if (reset_in || !(gain_pend || mute_pend)) begin
      wait_q <= '0;
    end else if (wait_q != CW'(TIMEOUT_CYCLES)) begin
      wait_q <= wait_q + CW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gain_out <= fcg_pkg::MUTE_CODE;
    end else if (gain_pend && (!gate_in || zc_rise || wait_q == CW'(TIMEOUT_CYCLES))) begin
      gain_out <= target_in; // RQ15 RQ16
    end
  end

  // Hardware mute ignores the gate input
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      muted_out <= 1'b1;
    end else if (mute_pend && (zc_rise || wait_q == CW'(TIMEOUT_CYCLES))) begin
      muted_out <= mute_req_in; // RQ19
    end
  end
endmodule : fcg_gain_channel

// file: fcg_host_model.sv
// Host model driving the three-wire serial port
`timescale 1ns/1ps
module fcg_host_model (
  input wire logic clk_in,
  input wire logic serial_out_in,
  output logic sclk_out = 1'b0,
  output logic sel_n_out = 1'b1,
  output logic data_out = 1'b0
);
  task automatic half;
    repeat (4) @(posedge clk_in);
  endtask : half
  task automatic send(input logic [63:0] w, input int n, input logic sel, output logic [31:0] echo);
    @(posedge clk_in);
    sel_n_out <= ~sel;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sclk_out <= 1'b0;
      data_out <= w[i];
      half();
      sclk_out <= 1'b1;
      half();
      echo = {echo[30:0], serial_out_in};
    end
    sclk_out <= 1'b0;
    half();
    sel_n_out <= 1'b1;
    data_out <= ~data_out;
  endtask : send
endmodule : fcg_host_model

// file: fcg_link_sync.sv
// Synchroniser and edge finder for the serial port pins
`timescale 1ns/1ps
module fcg_link_sync (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic serial_in,
  output fcg_pkg::fcg_link_t link_out
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= 3'h3;
      sync_q <= 3'h3;
      sclk_prev_q <= 1'b0;
    end else begin
      meta_q <= {sclk_in, sel_n_in, serial_in};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[2];
    end
  end

  always_comb begin
    link_out.sclk_rise = sync_q[2] & ~sclk_prev_q;
    link_out.sclk_fall = ~sync_q[2] & sclk_prev_q;
    link_out.sel_n = sync_q[1];
    link_out.data = sync_q[0];
  end
endmodule : fcg_link_sync

// file: fcg_monitor.sv
// Port checker for the gain control block
`timescale 1ns/1ps
module fcg_monitor (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sel_n_in,
  input wire logic hw_mute_n_in,
  input wire logic serial_out,
  input wire logic serial_oe_out,
  input wire logic [31:0] gain_out,
  input wire logic [3:0] ch_ground_out,
  input wire logic [3:0] hw_muted_out,
  input wire logic cal_active_out,
  input wire logic por_active_out
);
  logic [3:0] zero_codes;
  assign zero_codes = {gain_out[7:0] == 8'h00, gain_out[15:8] == 8'h00, gain_out[23:16] == 8'h00,
    gain_out[31:24] == 8'h00};
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_por_end;
    $fell(por_active_out) ##[0:2] cal_active_out;
  endsequence
  sequence s_cal_zero;
    ##[1:300] !cal_active_out && gain_out == 32'h0;
  endsequence
  a_por_cal_zero: assert property (s_por_end |-> s_cal_zero)
    else $error("no zero codes");
  a_por_muted: assert property (por_active_out |-> hw_muted_out == 4'hF)
    else $error("reset not muted");
  a_sel_oe_on: assert property ($fell(sel_n_in) |-> ##[1:6] serial_oe_out)
    else $error("output not driven");
  a_sel_oe_off: assert property ($rose(sel_n_in) |-> ##[1:6] !serial_oe_out)
    else $error("output not released");
  a_idle_quiet: assert property ((sel_n_in && !por_active_out) [*8] |-> !serial_oe_out && $stable(serial_out))
    else $error("busy while deselected");
  a_ground_code: assert property ($stable(gain_out) [*3] |-> ch_ground_out == zero_codes)
    else $error("ground flags wrong");
  a_hw_mute_on: assert property ($fell(hw_mute_n_in) && !por_active_out |-> ##[1:60] hw_muted_out == 4'hF)
    else $error("mute late");
  a_hw_mute_cal: assert property ($fell(hw_mute_n_in) && !cal_active_out && !por_active_out |-> ##[1:8] cal_active_out)
    else $error("no calibration");
endmodule : fcg_monitor

bind fcg_top fcg_monitor i_fcg_monitor (.*);

// file: fcg_pkg.sv
// Package with constants and carrier types for the four-channel gain control
package fcg_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int POR_MS = 100;
  localparam int POR_CYCLES = (CLK_HZ / 1000) * POR_MS;
  localparam int ZC_TIMEOUT_MS = 16;
  localparam int ZC_TIMEOUT_CYCLES = (CLK_HZ / 1000) * ZC_TIMEOUT_MS;
  localparam int CAL_CYCLES = 64;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 8;
  localparam int WORD_W = NUM_CH * CODE_W;
  localparam logic [7:0] MUTE_CODE = 8'h00;

  typedef enum logic [3:0] {
    FCG_POR = 4'h1,
    FCG_CAL = 4'h2,
    FCG_RUN = 4'h4,
    FCG_LOSS = 4'h8
  } fcg_state_t;

  typedef struct packed {
    logic sclk_rise;
    logic sclk_fall;
    logic sel_n;
    logic data;
  } fcg_link_t;
endpackage : fcg_pkg

// file: fcg_top.sv
// Serial control, sequencing and mute logic for the four-channel gain control
`timescale 1ns/1ps
// Functional notes
// RQ1: Hold reset about 100 ms, hardware muted.
// RQ2: Start offset calibration when reset ends.
// RQ3: After calibration all codes zero until written.
// RQ4: Supply loss mutes; recovery reruns power-up.
// RQ5: Accept data only while select low.
// RQ6: Capture 32-bit word, four 8-bit codes.
// RQ7: Codes arrive MSB first, unsigned.
// RQ8: Sample serial input on clock rise.
// RQ9: Output tri-state when deselected, falls update.
// RQ10: Code zero mutes channel to ground.
// RQ11: Codes 1-255 give 31.5 minus half-dB steps.
// RQ12: Chained devices form 32-bit-per-device shift register.
// RQ13: Host holds select 32 clocks per device.
// RQ14: Zero-cross enable low off, high on.
// RQ15: Gating per channel, only on change.
// RQ16: Apply on positive crossing or 16 ms.
// RQ17: Hardware mute pin and all-zero software mute.
// RQ18: Hardware mute input is active low.
// RQ19: Hardware mute waits crossing or timeout always.
// RQ20: Hardware mute also starts offset calibration.
// RQ21: Select rise loads word; channel 1 first.
// RQ22: Output shows far end of shift register.
module fcg_top #(
  parameter int POR_CYCLES = fcg_pkg::POR_CYCLES,
  parameter int TIMEOUT_CYCLES = fcg_pkg::ZC_TIMEOUT_CYCLES,
  parameter int CAL_CYCLES = fcg_pkg::CAL_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  input wire logic sel_n_in,
  input wire logic serial_in,
  input wire logic zero_cross_enable_in,
  input wire logic hw_mute_n_in,
  input wire logic supply_ok_in,
  input wire logic [3:0] zero_cross_in,
  output logic serial_out,
  output logic serial_oe_out,
  output logic [31:0] gain_out,
  output logic [3:0] ch_ground_out,
  output logic [3:0] hw_muted_out,
  output logic cal_active_out,
  output logic por_active_out
);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int KW = $clog2(CAL_CYCLES + 1);

  fcg_pkg::fcg_link_t link;
  fcg_pkg::fcg_state_t state_q;
  logic [PW-1:0] por_cnt_q;
  logic [KW-1:0] cal_cnt_q;
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic zc_en;
  logic hw_mute_n;
  logic supply_ok;
  logic hw_mute_prev_q;
  logic [31:0] shift_q;
  logic [31:0] target_q;
  logic sel_prev_q;
  logic out_bit_q;
  logic oe_q;
  logic core_reset;
  logic [31:0] gain_w;
  logic [3:0] muted_w;
  logic [3:0] ground_w;
  logic mute_fall;
  logic por_done;
  logic cal_done;
  logic shift_en;
  logic out_en;
  logic sel_rise;

  if (POR_CYCLES < 1) begin : g_bad_por
    $error("Power-up count must be at least one cycle");
  end
  if (CAL_CYCLES < 1) begin : g_bad_cal
    $error("Calibration count must be at least one cycle");
  end
  if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
    $error("Timeout must be at least one cycle");
  end
  if (fcg_pkg::WORD_W != 32) begin : g_bad_word
    $error("Ports serve four 8-bit codes only");
  end

  fcg_link_sync u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .sclk_in(sclk_in),
    .sel_n_in(sel_n_in),
    .serial_in(serial_in),
    .link_out(link)
  );

  // Level pins through two flip-flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_meta_q <= 3'h2;
      pin_sync_q <= 3'h2;
    end else begin
      pin_meta_q <= {zero_cross_enable_in, hw_mute_n_in, supply_ok_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign zc_en = pin_sync_q[2];
  assign hw_mute_n = pin_sync_q[1]; // RQ18
  assign supply_ok = pin_sync_q[0];

  // Previous level of the synchronised mute pin
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      hw_mute_prev_q <= 1'b1;
    end else begin
      hw_mute_prev_q <= hw_mute_n;
    end
  end

  assign mute_fall = hw_mute_prev_q && !hw_mute_n;
  assign por_done = por_cnt_q == PW'(POR_CYCLES - 1);
  assign cal_done = cal_cnt_q == KW'(CAL_CYCLES - 1);

  // Power-up, calibration and supply-loss sequencing
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= fcg_pkg::FCG_POR;
    end else begin
      unique case (state_q)
        fcg_pkg::FCG_POR: begin
          if (supply_ok && por_done) begin
            state_q <= fcg_pkg::FCG_CAL; // RQ1 RQ2
          end
        end
        fcg_pkg::FCG_CAL: begin
          if (!supply_ok) begin
            state_q <= fcg_pkg::FCG_LOSS;
          end else if (cal_done) begin
            state_q <= fcg_pkg::FCG_RUN;
          end
        end
        fcg_pkg::FCG_RUN: begin
          if (!supply_ok) begin
            state_q <= fcg_pkg::FCG_LOSS; // RQ4
          end else if (mute_fall) begin
            state_q <= fcg_pkg::FCG_CAL; // RQ20
          end
        end
        fcg_pkg::FCG_LOSS: begin
          if (supply_ok) begin
            state_q <= fcg_pkg::FCG_POR; // RQ4
          end
        end
        default: begin
          state_q <= fcg_pkg::FCG_POR;
        end
      endcase
    end
  end

  // Power-up timer, restarted while the supply is low
  always_ff @(posedge clk_in) begin
    if (reset_in || state_q != fcg_pkg::FCG_POR || !supply_ok) begin
      por_cnt_q <= '0;
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + PW'(1); // RQ1
    end
  end

  // Calibration timer, cleared outside calibration
  always_ff @(posedge clk_in) begin
    if (reset_in || state_q != fcg_pkg::FCG_CAL) begin
      cal_cnt_q <= '0;
    end else if (!cal_done) begin
      cal_cnt_q <= cal_cnt_q + KW'(1); // RQ2
    end
  end

  // Internal flip-flops cleared during power-up and supply loss
  assign core_reset = reset_in || state_q == fcg_pkg::FCG_POR || state_q == fcg_pkg::FCG_LOSS; // RQ1 RQ4

  // Link strobes qualified by the select
  assign shift_en = !link.sel_n && link.sclk_rise; // RQ5 RQ8
  assign out_en = !link.sel_n && link.sclk_fall; // RQ9
  assign sel_rise = link.sel_n && !sel_prev_q; // RQ21

  // Shift register: sample on rise while selected, MSB first
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      shift_q <= '0;
    end else if (shift_en) begin
      shift_q <= {shift_q[30:0], link.data}; // RQ5 RQ6 RQ7 RQ8 RQ12
    end
  end

  // Previous level of the synchronised select
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      sel_prev_q <= 1'b1;
    end else begin
      sel_prev_q <= link.sel_n;
    end
  end

  // Transfer on select rise; channel 1 in the first byte sent
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      target_q <= '0; // RQ3
    end else if (sel_rise) begin
      target_q <= shift_q; // RQ21
    end
  end

  // Serial output enable follows the select
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !link.sel_n; // RQ9
    end
  end

  // Serial output bit updated on falls
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      out_bit_q <= 1'b0;
    end else if (out_en) begin
      out_bit_q <= shift_q[31]; // RQ9 RQ22
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < fcg_pkg::NUM_CH; ch++) begin : g_ch
      fcg_gain_channel #(
        .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
      ) u_ch (
        .clk_in(clk_in),
        .reset_in(core_reset),
        .target_in(target_q[31 - 8 * ch -: 8]),
        .gate_in(zc_en), // RQ14
        .mute_req_in(!hw_mute_n), // RQ17
        .zero_cross_in(zero_cross_in[ch]),
        .gain_out(gain_w[31 - 8 * ch -: 8]),
        .muted_out(muted_w[ch])
      );
      assign ground_w[ch] = gain_w[31 - 8 * ch -: 8] == fcg_pkg::MUTE_CODE; // RQ10 RQ17
    end
  endgenerate

  // Applied gains and ground flags
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      gain_out <= '0;
      ch_ground_out <= 4'hF;
    end else begin
      gain_out <= gain_w; // RQ11
      ch_ground_out <= ground_w; // RQ10 RQ17
    end
  end

  // Hardware mute flags, forced while power-up or supply loss holds
  always_ff @(posedge clk_in) begin
    if (core_reset) begin
      hw_muted_out <= 4'hF;
    end else begin
      hw_muted_out <= muted_w | {4{state_q != fcg_pkg::FCG_RUN && state_q != fcg_pkg::FCG_CAL}}; // RQ1 RQ4
    end
  end

  // Daisy-chain data pin
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= out_bit_q;
    end
  end

  // Daisy-chain driver enable
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      serial_oe_out <= 1'b0;
    end else begin
      serial_oe_out <= oe_q;
    end
  end

  // Calibration status
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cal_active_out <= 1'b0;
    end else begin
      cal_active_out <= state_q == fcg_pkg::FCG_CAL; // RQ2
    end
  end

  // Power-up or supply-loss status
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      por_active_out <= 1'b1;
    end else begin
      por_active_out <= state_q == fcg_pkg::FCG_POR || state_q == fcg_pkg::FCG_LOSS;
    end
  end
endmodule : fcg_top

// file: fcg_top_tb.sv
// Testbench for the gain control block
`timescale 1ns/1ps
module fcg_top_tb;
  logic clk_in = 1'b0, reset_in = 1'b1, zero_cross_enable_in = 1'b0, hw_mute_n_in = 1'b1, supply_ok_in = 1'b1;
  logic [3:0] zero_cross_in = 4'h0;
  logic sclk_in, sel_n_in, serial_in, serial_out, serial_oe_out, cal_active_out, por_active_out;
  logic [31:0] gain_out, echo;
  logic [3:0] ch_ground_out, hw_muted_out;
  int err_total = 0;
  int n_tests = 0;
  wire [37:0] state = {por_active_out, cal_active_out, hw_muted_out, gain_out};
  always #50 clk_in = ~clk_in;
  fcg_top #(.POR_CYCLES(50), .TIMEOUT_CYCLES(40), .CAL_CYCLES(8)) i_fcg_top (.*);
  fcg_host_model i_fcg_host_model (.clk_in, .serial_out_in(serial_out), .sclk_out(sclk_in), .sel_n_out(sel_n_in),
    .data_out(serial_in));
  task automatic check(input logic [37:0] seen, input logic [37:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("%0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_for(input logic [37:0] goal, input int lim);
    for (int i = 0; i < lim && state !== goal; i++) @(posedge clk_in);
    check(state, goal);
    if (state !== goal) begin
      report_and_stop();
    end
  endtask : wait_for
  task automatic t_power_up;
    check({27'h0, por_active_out, hw_muted_out}, 32'h1F);
    wait_for(38'h0, 300);
    check({28'h0, ch_ground_out}, 32'hF);
  endtask : t_power_up
  task automatic t_daisy;
    i_fcg_host_model.send({32'hA5C3_0F96, 32'h0001_FF00}, 64, 1'b1, echo);
    wait_for({6'h0, 32'h0001_FF00}, 20);
    check(echo, 32'hA5C3_0F96);
    check({28'h0, ch_ground_out}, 32'h9);
    i_fcg_host_model.send({32'h0, 32'h0}, 32, 1'b0, echo);
    repeat (8) @(posedge clk_in);
    check({serial_oe_out, gain_out[30:0]}, 32'h0001_FF00);
  endtask : t_daisy
  task automatic t_gate;
    zero_cross_enable_in <= 1'b1;
    i_fcg_host_model.send({32'h0, 32'h1122_3344}, 32, 1'b1, echo);
    repeat (8) @(posedge clk_in);
    check(gain_out, 32'h0001_FF00);
    zero_cross_in <= 4'h9;
    repeat (8) @(posedge clk_in);
    check(gain_out, 32'h1101_FF44);
    wait_for({6'h0, 32'h1122_3344}, 60);
  endtask : t_gate
  task automatic t_hw_mute;
    hw_mute_n_in <= 1'b0;
    wait_for({6'h0F, 32'h1122_3344}, 80);
    hw_mute_n_in <= 1'b1;
    wait_for({6'h00, 32'h1122_3344}, 80);
  endtask : t_hw_mute
  task automatic t_supply;
    supply_ok_in <= 1'b0;
    wait_for({6'h2F, 32'h0}, 20);
    supply_ok_in <= 1'b1;
    t_power_up();
  endtask : t_supply
  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    t_power_up();
    t_daisy();
    t_gate();
    t_hw_mute();
    t_supply();
    report_and_stop();
  end
endmodule : fcg_top_tb
